// File: logic/host_bus_slave_and_clock_control.sv
// Host bus slave port, clock and phase control of the channel interface
// Summary of operation
// - Answer one aligned block of 16 word addresses; upper bits match base.
// - Default base places block at 776200, offsets 00 to 37.
// - Match releases two sync stages; second stage drives slave sync.
// - Sync stages advance only on the negative phase clock enable.
// - Write data captured by write enable pulse at clock leading edge.
// - Address bits 4:1 decode to select lines while matched.
// - Read data is a 16 to 1 multiplexer per bit, gated by data enable.
// - Extended address bits 17:16 advance on buffer address carry.
// - Interrupt priority level customarily 4.
// - Free running 200 ns basic clock with negative and positive trains.
// - Maintenance clock enable stops the gated clock only.
// - Writing bit 0 in maintenance mode yields exactly one gated pulse.
// - Step latch toggles per closure, fires pulse, then is cleared.
// - Time state toggles each gated negative clock; with phase gives 16 slots.
// - Maintenance out writes latch into hold register by byte enables while on line and cabled.
// - Reset clears hold register, then leaves operational out set.
// - Writing bit 2 to location 24 sets the fast service arm.
// - Armed and off line, rising service in gives immediate service out.
// - Channel get off reset forces phase four.
// - Interface reset at phase 7, second time state, with stop.
// - Transition permit needs bit_a clear, no stack, no chaining, tags clear.
// - On line state entered only when request meets permit.
// - Three phase bits encode one of eight phases in binary.
`include "host_port_map.svh"
module host_bus_slave_and_clock_control
  import host_port_pkg::*;
#(
  parameter logic [17:0] BLOCK_BASE = `BLOCK_BASE_DEFAULT,
  parameter logic [2:0] IRQ_LEVEL = `IRQ_LEVEL_DEFAULT
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_bus_init,
  input wire logic [17:0] i_bus_addr,
  input wire logic [15:0] i_bus_data,
  input wire logic i_master_sync,
  input wire logic i_write_high,
  input wire logic i_write_low,
  input wire logic i_data_to_bus_en,
  input wire logic i_step_input,
  input wire logic i_service_in,
  input wire logic i_channel_get_off_reset,
  input wire logic i_stacked_status,
  input wire logic i_command_chaining,
  input wire logic i_in_tags_active,
  input wire logic i_cabled,
  input wire logic i_buffer_address_carry,
  input wire logic [2:0] i_next_phase,
  input wire logic i_phase_load,
  input wire logic [15:0] i_reg_bank [16],
  output logic o_slave_sync,
  output logic [15:0] o_read_mux_data,
  output logic o_read_data_en,
  output logic [15:0] o_address_select,
  output logic [15:0] o_write_data,
  output logic o_write_enable_pulse,
  output logic [1:0] o_ext_addr,
  output logic [2:0] o_irq_level,
  output logic [15:0] o_maint_out_hold,
  output logic o_fast_service_response,
  output logic o_gated_clock_pos,
  output logic o_gated_clock_neg,
  output logic o_time_state_toggle,
  output logic [2:0] o_phase,
  output logic [15:0] o_phase_slot,
  output logic o_interface_reset,
  output logic o_online_transition_permit,
  output logic o_online_state
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NSYNC = 11;
  wire logic [NSYNC-1:0] raw_in = {i_master_sync, i_write_high, i_write_low, i_data_to_bus_en, i_step_input,
    i_service_in, i_channel_get_off_reset, i_stacked_status, i_command_chaining, i_in_tags_active, i_cabled};
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [17:0] addr_a;
  logic [17:0] addr_b;
  logic [15:0] data_a;
  logic [15:0] data_b;
  always_ff @(posedge i_clock) begin
    sync_a <= raw_in;
    sync_b <= sync_a;
    addr_a <= i_bus_addr;
    addr_b <= addr_a;
    data_a <= i_bus_data;
    data_b <= data_a;
  end
  wire logic msync = sync_b[10];
  wire logic wr_high = sync_b[9];
  wire logic wr_low = sync_b[8];
  wire logic data_en = sync_b[7];
  wire logic step_in = sync_b[6];
  wire logic service_in = sync_b[5];
  wire logic get_off = sync_b[4];
  wire logic stacked = sync_b[3];
  wire logic chaining = sync_b[2];
  wire logic tags_in = sync_b[1];
  wire logic cabled = sync_b[0];

  // ----------------------------------------
  // Clock generator
  // ----------------------------------------
  logic maint_clk_en;
  logic maint_pulse;
  logic negative_phase_clock;
  logic positive_phase_clock;
  logic gated_clock_neg;
  logic gated_clock_pos;
  basic_clock_gen u_clock (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_maint_mode(maint_clk_en),
    .i_maint_pulse(maint_pulse),
    .o_negative_phase_clock(negative_phase_clock),
    .o_positive_phase_clock(positive_phase_clock),
    .o_gated_clock_neg(gated_clock_neg),
    .o_gated_clock_pos(gated_clock_pos)
  );

  // ----------------------------------------
  // Address decode and select lines
  // ----------------------------------------
  wire logic [3:0] word_sel = addr_b[`SEL_ADDR_HI:`SEL_ADDR_LO];
  wire logic address_match_flag = msync &&
    (addr_b[`BLOCK_ADDR_HI:`BLOCK_ADDR_LO] == BLOCK_BASE[`BLOCK_ADDR_HI:`BLOCK_ADDR_LO]);
  wire logic [4:0] offset = {word_sel, 1'b0};
  wire logic [15:0] next_address_select = address_match_flag ? (16'h0001 << word_sel) : 16'h0000;

  // ----------------------------------------
  // Slave sync handshake
  // ----------------------------------------
  sync_state_e sync_state;
  sync_state_e next_sync_state;
  always_comb begin
    next_sync_state = sync_state;
    unique case (sync_state)
      SYNC_IDLE: begin
        if (address_match_flag && negative_phase_clock) begin
          next_sync_state = SYNC_FIRST;
        end
      end
      SYNC_FIRST: begin
        if (!address_match_flag) begin
          next_sync_state = SYNC_IDLE;
        end else if (negative_phase_clock) begin
          next_sync_state = SYNC_ANSWER;
        end
      end
      SYNC_ANSWER: begin
        if (!msync) begin
          next_sync_state = SYNC_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || i_bus_init) begin
      sync_state <= SYNC_IDLE;
    end else begin
      sync_state <= next_sync_state;
    end
  end
  wire logic entering_answer = (sync_state == SYNC_FIRST) && (next_sync_state == SYNC_ANSWER);
  wire logic write_enable_pulse = entering_answer && (wr_high || wr_low);
  wire logic wr_hi_pulse = entering_answer && wr_high;
  wire logic wr_lo_pulse = entering_answer && wr_low;

  // ----------------------------------------
  // Control flip-flops written by the host
  // ----------------------------------------
  wire logic hit_error_status = wr_lo_pulse && (offset == `OFF_ERROR_STATUS);
  wire logic hit_control_loc = wr_lo_pulse && (offset == `OFF_CONTROL_LOC);
  wire logic hit_control_bits = wr_lo_pulse && (offset == `OFF_CONTROL_BITS);
  wire logic hold_write = (offset == `OFF_MAINT_OUT) && o_online_state && cabled;
  logic fast_service_arm;
  logic online_request;
  logic bit_a;
  logic stop_request;
  logic single_step_latch;
  logic step_prev;
  logic service_prev;
  logic time_state_toggle;
  logic [2:0] phase;
  logic [1:0] ext_addr;
  logic hold_set_pending;
  logic [15:0] maint_out_hold;

  wire logic step_pulse = single_step_latch && positive_phase_clock;
  wire logic next_maint_pulse = maint_clk_en && !maint_pulse &&
    ((hit_error_status && data_b[`BIT_MAINT_CLK_PULSE]) || step_pulse);
  wire logic iface_clear = o_interface_reset || i_bus_init;
  wire logic phase7_state2_signal = (phase == `PHASE_SEVEN) && !time_state_toggle;
  wire logic next_interface_reset = phase7_state2_signal && stop_request && gated_clock_neg;
  wire logic online_transition_permit = !bit_a && !stacked && !chaining && !tags_in;
  wire logic fast_service_response = fast_service_arm && !o_online_state && service_in && !service_prev;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || i_bus_init) begin
      maint_clk_en <= 1'b0;
      maint_pulse <= 1'b0;
      online_request <= 1'b0;
      bit_a <= 1'b0;
      stop_request <= 1'b0;
      o_online_state <= 1'b0;
    end else begin
      if (hit_error_status) begin
        maint_clk_en <= data_b[`BIT_MAINT_CLK_EN];
      end
      maint_pulse <= next_maint_pulse;
      if (hit_control_bits) begin
        online_request <= data_b[`BIT_ONLINE_REQ];
        bit_a <= data_b[`BIT_BIT_A];
        stop_request <= data_b[`BIT_STOP];
      end
      if (!online_request) begin
        o_online_state <= 1'b0;
      end else if (online_transition_permit) begin
        o_online_state <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || iface_clear) begin
      fast_service_arm <= 1'b0;
    end else if (hit_control_loc) begin
      fast_service_arm <= data_b[`BIT_FAST_SERVICE];
    end
  end

  // ----------------------------------------
  // Single step latch
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      single_step_latch <= 1'b0;
      step_prev <= 1'b0;
      service_prev <= 1'b0;
    end else begin
      step_prev <= step_in;
      service_prev <= service_in;
      if (step_in && !step_prev) begin
        single_step_latch <= !single_step_latch;
      end else if (maint_pulse) begin
        single_step_latch <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Time state and phase machine
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || iface_clear) begin
      time_state_toggle <= 1'b1;
      phase <= 3'h0;
    end else if (gated_clock_neg) begin
      time_state_toggle <= !time_state_toggle;
      if (get_off) begin
        phase <= `PHASE_FOUR;
      end else if (i_phase_load) begin
        phase <= i_next_phase;
      end
    end
  end
  wire logic [15:0] next_phase_slot = 16'h0001 << {phase, !time_state_toggle};

  // ----------------------------------------
  // Extended address counter
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || iface_clear) begin
      ext_addr <= 2'h0;
    end else if (i_buffer_address_carry) begin
      ext_addr <= ext_addr + 2'h1;
    end
  end

  // ----------------------------------------
  // Maintenance out hold register
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || iface_clear) begin
      maint_out_hold <= 16'h0000;
      hold_set_pending <= 1'b1;
    end else begin
      hold_set_pending <= 1'b0;
      if (hold_set_pending) begin
        maint_out_hold <= maint_out_hold | `HOLD_RESET;
      end else begin
        if (wr_hi_pulse && hold_write) begin
          maint_out_hold[15:8] <= data_b[15:8];
        end
        if (wr_lo_pulse && hold_write) begin
          maint_out_hold[7:0] <= data_b[7:0];
        end
      end
    end
  end

  // ----------------------------------------
  // Read multiplexer, one slice per bit
  // ----------------------------------------
  wire logic [15:0] read_mux_data;
  genvar b;
  generate
    for (b = 0; b < 16; b++) begin : g_slice
      assign read_mux_data[b] = i_reg_bank[word_sel][b];
    end
  endgenerate
  wire logic read_active = data_en && address_match_flag && (sync_state != SYNC_IDLE);

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_slave_sync <= 1'b0;
      o_read_mux_data <= 16'h0000;
      o_read_data_en <= 1'b0;
      o_address_select <= 16'h0000;
      o_write_data <= 16'h0000;
      o_write_enable_pulse <= 1'b0;
      o_ext_addr <= 2'h0;
      o_irq_level <= 3'h0;
      o_maint_out_hold <= 16'h0000;
      o_fast_service_response <= 1'b0;
      o_gated_clock_pos <= 1'b0;
      o_gated_clock_neg <= 1'b0;
      o_time_state_toggle <= 1'b1;
      o_phase <= 3'h0;
      o_phase_slot <= 16'h0000;
      o_interface_reset <= 1'b0;
      o_online_transition_permit <= 1'b0;
    end else begin
      o_slave_sync <= (next_sync_state == SYNC_ANSWER);
      o_read_mux_data <= read_active ? read_mux_data : 16'h0000;
      o_read_data_en <= read_active;
      o_address_select <= next_address_select;
      o_write_data <= data_b;
      o_write_enable_pulse <= write_enable_pulse;
      o_ext_addr <= ext_addr;
      o_irq_level <= IRQ_LEVEL;
      o_maint_out_hold <= maint_out_hold;
      o_fast_service_response <= fast_service_response;
      o_gated_clock_pos <= gated_clock_pos;
      o_gated_clock_neg <= gated_clock_neg;
      o_time_state_toggle <= time_state_toggle;
      o_phase <= phase;
      o_phase_slot <= next_phase_slot;
      o_interface_reset <= next_interface_reset;
      o_online_transition_permit <= online_transition_permit;
    end
  end
endmodule

// File: logic/host_port_map.svh
// Register offsets, field positions, reset values and timing counts for the host port
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH
`define BLOCK_BASE_DEFAULT 18'o776200
`define BLOCK_ADDR_HI 17
`define BLOCK_ADDR_LO 5
`define SEL_ADDR_HI 4
`define SEL_ADDR_LO 1
`define OFF_ERROR_STATUS 5'o14
`define OFF_MAINT_OUT 5'o14
`define OFF_CONTROL_LOC 5'o24
`define OFF_CONTROL_BITS 5'o26
`define OFF_STATUS_EXT 5'o30
`define BIT_MAINT_CLK_EN 1
`define BIT_MAINT_CLK_PULSE 0
`define BIT_FAST_SERVICE 2
`define BIT_ONLINE_REQ 0
`define BIT_BIT_A 1
`define BIT_STOP 2
`define BIT_OPL_OUT 7
`define HOLD_RESET 16'h8000
`define IRQ_LEVEL_DEFAULT 3'h4
`define CLOCK_PERIOD_NS 20
`define BASIC_PERIOD_NS 200
`define BASIC_DIV ((`BASIC_PERIOD_NS) / (`CLOCK_PERIOD_NS))
`define PHASE_FOUR 3'h4
`define PHASE_SEVEN 3'h7
`endif

// File: logic/host_port_pkg.sv
// Types shared by the host port logic
package host_port_pkg;
  typedef enum logic [2:0] {
    SYNC_IDLE = 3'b001,
    SYNC_FIRST = 3'b010,
    SYNC_ANSWER = 3'b100
  } sync_state_e;
  typedef logic [15:0] word_t;
endpackage

// File: logic/basic_clock_gen.sv
// Free running basic clock divider with gated maintenance pulses
`include "host_port_map.svh"
module basic_clock_gen
  import host_port_pkg::*;
#(
  parameter int DIV = `BASIC_DIV
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_maint_mode,
  input wire logic i_maint_pulse,
  output logic o_negative_phase_clock,
  output logic o_positive_phase_clock,
  output logic o_gated_clock_neg,
  output logic o_gated_clock_pos
);
  logic [7:0] count;
  wire logic wrap = (count == 8'(DIV - 1));
  wire logic half = (count == 8'(DIV / 2 - 1));
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      count <= 8'h00;
    end else begin
      count <= wrap ? 8'h00 : count + 8'h01;
    end
  end
  // ----------------------------------------
  // Free running trains and gated copies
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_negative_phase_clock <= 1'b0;
      o_positive_phase_clock <= 1'b0;
      o_gated_clock_neg <= 1'b0;
      o_gated_clock_pos <= 1'b0;
    end else begin
      o_negative_phase_clock <= wrap;
      o_positive_phase_clock <= half;
      o_gated_clock_neg <= i_maint_mode ? i_maint_pulse : wrap;
      o_gated_clock_pos <= i_maint_mode ? i_maint_pulse : half;
    end
  end
endmodule

// File: sim/host_bus_slave_and_clock_control_properties.sv
// Concurrent checks on the host port control block
module host_bus_slave_and_clock_control_properties
  import host_port_pkg::*;
#(
  parameter logic [17:0] BLOCK_BASE = 18'o776200,
  parameter logic [2:0] IRQ_LEVEL = 3'h4
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_master_sync,
  input wire logic i_data_to_bus_en,
  input wire logic i_stacked_status,
  input wire logic i_buffer_address_carry,
  input wire logic o_slave_sync,
  input wire logic [15:0] o_read_mux_data,
  input wire logic o_read_data_en,
  input wire logic [15:0] o_address_select,
  input wire logic o_write_enable_pulse,
  input wire logic [1:0] o_ext_addr,
  input wire logic [2:0] o_irq_level,
  input wire logic [15:0] o_maint_out_hold,
  input wire logic o_gated_clock_neg,
  input wire logic o_online_transition_permit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------
  // Handshake and data path
  // ----------------------------------------
  sequence master_gone;
    !i_master_sync [*6];
  endsequence
  sequence answer_then_pulse_end;
    o_slave_sync ##1 !o_write_enable_pulse;
  endsequence
  select_onehot_a: assert property ($onehot0(o_address_select))
    else $error("select lines not one-hot");
  read_gate_a: assert property (!o_read_data_en |-> o_read_mux_data == 16'h0000)
    else $error("read data without enable");
  read_enable_a: assert property (!i_data_to_bus_en [*4] |-> !o_read_data_en)
    else $error("read enable without bus enable");
  sync_release_a: assert property (master_gone |-> !o_slave_sync)
    else $error("slave sync kept after master left");
  sync_hold_a: assert property (o_slave_sync && i_master_sync |=> o_slave_sync)
    else $error("slave sync dropped early");
  write_pulse_a: assert property (o_write_enable_pulse |-> answer_then_pulse_end)
    else $error("write pulse outside answer");
  // ----------------------------------------
  // Clock, status and hold register
  // ----------------------------------------
  irq_level_a: assert property ($past(i_rst_n, 2) |-> o_irq_level == IRQ_LEVEL)
    else $error("priority level wrong");
  gated_pulse_a: assert property (o_gated_clock_neg |=> !o_gated_clock_neg [*4])
    else $error("gated clock pulses too close");
  permit_block_a: assert property (i_stacked_status [*4] |-> !o_online_transition_permit)
    else $error("permit with stacked status");
  ext_step_a: assert property (i_buffer_address_carry |-> ##2 o_ext_addr == $past(o_ext_addr, 2) + 2'h1)
    else $error("extended address did not advance");
  hold_reset_a: assert property ($rose(i_rst_n) |-> ##[1:3] o_maint_out_hold == 16'h8000)
    else $error("hold register not left at operational out");
endmodule

bind host_bus_slave_and_clock_control host_bus_slave_and_clock_control_properties #(
  .BLOCK_BASE(BLOCK_BASE), .IRQ_LEVEL(IRQ_LEVEL)
) u_host_bus_slave_and_clock_control_properties (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_master_sync(i_master_sync), .i_data_to_bus_en(i_data_to_bus_en),
  .i_stacked_status(i_stacked_status), .i_buffer_address_carry(i_buffer_address_carry),
  .o_slave_sync(o_slave_sync), .o_read_mux_data(o_read_mux_data), .o_read_data_en(o_read_data_en),
  .o_address_select(o_address_select), .o_write_enable_pulse(o_write_enable_pulse), .o_ext_addr(o_ext_addr),
  .o_irq_level(o_irq_level), .o_maint_out_hold(o_maint_out_hold), .o_gated_clock_neg(o_gated_clock_neg),
  .o_online_transition_permit(o_online_transition_permit)
);

// File: sim/host_master.sv
// Host processor model acting as bus master
module host_master
  import host_port_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_slave_sync,
  input wire logic [15:0] i_read_mux_data,
  output logic [17:0] o_bus_addr,
  output logic [15:0] o_bus_data,
  output logic o_master_sync,
  output logic o_write_high,
  output logic o_write_low,
  output logic o_data_to_bus_en
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {o_bus_addr, o_bus_data} = '0;
    {o_master_sync, o_write_high, o_write_low, o_data_to_bus_en} = '0;
  end
  // One bus cycle; neither byte enable means a read
  task automatic transfer(input logic [17:0] a, input word_t d, input logic hi, input logic lo,
                          output word_t rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 16'h0000;
    @(posedge i_clock);
    #2;
    o_bus_addr = a;
    o_bus_data = d;
    o_write_high = hi;
    o_write_low = lo;
    o_data_to_bus_en = !(hi || lo);
    o_master_sync = 1'b1;
    for (n = 0; n < 60 && !ok; n++) begin
      @(posedge i_clock);
      if (i_slave_sync === 1'b1) begin
        ok = 1'b1;
        rd = i_read_mux_data;
      end
    end
    #2;
    {o_master_sync, o_write_high, o_write_low, o_data_to_bus_en} = '0;
    for (n = 0; n < 20 && i_slave_sync !== 1'b0; n++) @(posedge i_clock);
    #2;
    // Released lines show the inverse so stale values never pass
    o_bus_addr = ~a;
    o_bus_data = ~d;
  endtask
endmodule

// File: sim/host_bus_slave_and_clock_control_test.sv
// Self-checking bench for the host port control block
`include "host_port_map.svh"
`define CHK(g, e) check_eq(18'(g), 18'(e))
module host_bus_slave_and_clock_control_test
  import host_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock, i_rst_n, i_bus_init, i_step_input, i_service_in, i_channel_get_off_reset;
  logic i_cabled, i_buffer_address_carry, i_phase_load, ok, ts_q;
  logic [2:0] blk, i_next_phase, o_phase;
  logic [17:0] bus_addr;
  logic [15:0] reg_bank [16];
  word_t bus_data, rd, sel_q, wd_q, o_read_mux_data, o_address_select, o_write_data, o_maint_out_hold, o_phase_slot;
  logic master_sync, write_high, write_low, data_en, o_slave_sync, o_read_data_en, o_write_enable_pulse;
  logic [1:0] o_ext_addr;
  logic [2:0] o_irq_level;
  logic o_fast_service_response, o_gated_clock_pos, o_gated_clock_neg, o_time_state_toggle;
  logic o_interface_reset, o_online_transition_permit, o_online_state;
  int failures = 0, tests_run = 0, gc, gp, tc, fc, rc;

  host_bus_slave_and_clock_control u_host_bus_slave_and_clock_control (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus_init(i_bus_init), .i_bus_addr(bus_addr), .i_bus_data(bus_data),
    .i_master_sync(master_sync), .i_write_high(write_high), .i_write_low(write_low), .i_data_to_bus_en(data_en),
    .i_step_input(i_step_input), .i_service_in(i_service_in), .i_channel_get_off_reset(i_channel_get_off_reset),
    .i_stacked_status(blk[0]), .i_command_chaining(blk[1]), .i_in_tags_active(blk[2]), .i_cabled(i_cabled),
    .i_buffer_address_carry(i_buffer_address_carry), .i_next_phase(i_next_phase), .i_phase_load(i_phase_load),
    .i_reg_bank(reg_bank), .o_slave_sync(o_slave_sync), .o_read_mux_data(o_read_mux_data),
    .o_read_data_en(o_read_data_en), .o_address_select(o_address_select), .o_write_data(o_write_data),
    .o_write_enable_pulse(o_write_enable_pulse), .o_ext_addr(o_ext_addr), .o_irq_level(o_irq_level),
    .o_maint_out_hold(o_maint_out_hold), .o_fast_service_response(o_fast_service_response),
    .o_gated_clock_pos(o_gated_clock_pos), .o_gated_clock_neg(o_gated_clock_neg),
    .o_time_state_toggle(o_time_state_toggle), .o_phase(o_phase), .o_phase_slot(o_phase_slot),
    .o_interface_reset(o_interface_reset), .o_online_transition_permit(o_online_transition_permit),
    .o_online_state(o_online_state)
  );
  host_master u_host_master (
    .i_clock(i_clock), .i_slave_sync(o_slave_sync), .i_read_mux_data(o_read_mux_data), .o_bus_addr(bus_addr),
    .o_bus_data(bus_data), .o_master_sync(master_sync), .o_write_high(write_high), .o_write_low(write_low),
    .o_data_to_bus_en(data_en)
  );
  // ----------------------------------------
  // Clock, watchdog and pulse counters
  // ----------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  initial begin
    #200000;
    failures++;
    summarize();
  end
  always @(posedge i_clock) begin
    if (o_gated_clock_neg === 1'b1) gc++;
    if (o_gated_clock_pos === 1'b1) gp++;
    if (o_fast_service_response === 1'b1) fc++;
    if (o_interface_reset === 1'b1) rc++;
    if (o_slave_sync === 1'b1) sel_q = o_address_select;
    if (o_write_enable_pulse === 1'b1) wd_q = o_write_data;
    if (o_time_state_toggle !== ts_q) tc++;
    ts_q = o_time_state_toggle;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #2;
  endtask
  task automatic check_eq(input logic [17:0] g, input logic [17:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] off, input word_t d, input logic hi, input logic lo);
    u_host_master.transfer(`BLOCK_BASE_DEFAULT | 18'(off), d, hi, lo, rd, ok);
    `CHK(ok, 1'b1);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {i_rst_n, i_bus_init, i_step_input, i_service_in, i_channel_get_off_reset, i_cabled} = '0;
    {i_buffer_address_carry, i_phase_load, blk, i_next_phase, ts_q} = '0;
    for (int k = 0; k < 16; k++) reg_bank[k] = 16'(k * 16'h1357 + 16'h00A5);
    tick(4);
    i_rst_n = 1'b1;
    tick(4);
    `CHK(o_irq_level, 3'h4);
    `CHK(o_maint_out_hold, `HOLD_RESET);
    `CHK(o_ext_addr, 2'h0);
    repeat (3) begin
      i_buffer_address_carry = 1'b1;
      tick(1);
      i_buffer_address_carry = 1'b0;
      tick(3);
    end
    `CHK(o_ext_addr, 2'h3);
    u_host_master.transfer(`BLOCK_BASE_DEFAULT ^ 18'o000040, 16'h0000, 1'b0, 1'b0, rd, ok);
    `CHK(ok, 1'b0);
    u_host_master.transfer(`BLOCK_BASE_DEFAULT ^ 18'o400000, 16'h0000, 1'b0, 1'b0, rd, ok);
    `CHK(ok, 1'b0);
    for (int k = 0; k < 16; k++) begin
      u_host_master.transfer(`BLOCK_BASE_DEFAULT | 18'(k * 2), 16'h0000, 1'b0, 1'b0, rd, ok);
      `CHK(rd, 16'(k * 16'h1357 + 16'h00A5));
      `CHK(sel_q, 16'h0001 << k);
    end
    wr(`OFF_CONTROL_LOC, 16'h0004, 1'b0, 1'b1);
    fc = 0;
    i_service_in = 1'b1;
    tick(8);
    `CHK(fc, 1);
    i_service_in = 1'b0;
    wr(`OFF_ERROR_STATUS, 16'h0002, 1'b0, 1'b1);
    gc = 0;
    tick(50);
    `CHK(gc, 0);
    gc = 0;
    wr(`OFF_ERROR_STATUS, 16'h0003, 1'b0, 1'b1);
    tick(20);
    `CHK(gc, 1);
    gc = 0;
    i_step_input = 1'b1;
    tick(30);
    i_step_input = 1'b0;
    tick(30);
    `CHK(gc, 1);
    wr(`OFF_ERROR_STATUS, 16'h0000, 1'b0, 1'b1);
    {gc, gp, tc} = '0;
    tick(100);
    `CHK(gc, 10);
    `CHK(gp, 10);
    `CHK(tc, 10);
    blk = 3'h1;
    tick(6);
    wr(`OFF_CONTROL_BITS, 16'h0001, 1'b0, 1'b1);
    tick(30);
    `CHK(o_online_state, 1'b0);
    for (int k = 0; k < 3; k++) begin
      blk = 3'h1 << k;
      tick(6);
      `CHK(o_online_transition_permit, 1'b0);
    end
    blk = 3'h0;
    wr(`OFF_CONTROL_BITS, 16'h0002, 1'b0, 1'b1);
    tick(6);
    `CHK(o_online_transition_permit, 1'b0);
    wr(`OFF_CONTROL_BITS, 16'h0001, 1'b0, 1'b1);
    tick(30);
    `CHK(o_online_transition_permit, 1'b1);
    `CHK(o_online_state, 1'b1);
    i_cabled = 1'b1;
    tick(4);
    wr(`OFF_MAINT_OUT, 16'hA530, 1'b1, 1'b1);
    tick(4);
    `CHK(o_maint_out_hold, 16'hA530);
    `CHK(wd_q, 16'hA530);
    wr(`OFF_MAINT_OUT, 16'h1200, 1'b1, 1'b0);
    tick(4);
    `CHK(o_maint_out_hold, 16'h1230);
    `CHK(wd_q, 16'h1200);
    i_bus_init = 1'b1;
    tick(2);
    i_bus_init = 1'b0;
    tick(4);
    `CHK(o_maint_out_hold, `HOLD_RESET);
    rc = 0;
    i_next_phase = `PHASE_SEVEN;
    i_phase_load = 1'b1;
    tick(12);
    i_phase_load = 1'b0;
    tick(2);
    `CHK(o_phase, `PHASE_SEVEN);
    `CHK(o_phase_slot & 16'h3FFF, 16'h0000);
    `CHK(rc, 0);
    wr(`OFF_CONTROL_BITS, 16'h0004, 1'b0, 1'b1);
    tick(30);
    `CHK(rc != 0, 1'b1);
    i_channel_get_off_reset = 1'b1;
    tick(30);
    `CHK(o_phase, `PHASE_FOUR);
    i_channel_get_off_reset = 1'b0;
    tick(4);
    summarize();
  end
endmodule
